// *** rtl/psr_pkg.sv ***
package psr_pkg;
  // Command and framing
  localparam logic [7:0] CMD_MEASURE    = 8'haa;
  localparam logic [7:0] CMD_PAD        = 8'h00;
  localparam logic [6:0] I2C_ADDR       = 7'h18;
  localparam int         READ_BYTES     = 4;
  localparam int         CMD_BYTES      = 3;
  // Status byte layout
  localparam int         ST_POWER_BIT   = 6;
  localparam int         ST_BUSY_BIT    = 5;
  localparam int         ST_MEMERR_BIT  = 2;
  localparam int         ST_SAT_BIT     = 0;
  // Timing, checksum and count limits
  localparam int         CLK_MHZ        = 100;
  localparam int         POWERUP_US     = 1;
  localparam int         POWERUP_CYC    = POWERUP_US * CLK_MHZ;
  localparam int         MEAS_US        = 10;
  localparam int         MEAS_CYC       = MEAS_US * CLK_MHZ;
  localparam int         CNT_W          = 16;
  localparam logic [23:0] MEM_SUM_GOOD  = 24'h000000;
  localparam logic [23:0] COUNT_MAX     = 24'hffffff;

  typedef struct packed {
    logic        powered;
    logic        busy;
    logic        mem_err;
    logic        sat;
    logic [23:0] count;
  } result_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;

  typedef struct packed {
    logic start;
    logic stop;
  } frame_t;

  function automatic logic [7:0] status_byte(input result_t r);
    logic [7:0] s;
    s = 8'h00;
    s[ST_POWER_BIT]  = r.powered;
    s[ST_BUSY_BIT]   = r.busy;
    s[ST_MEMERR_BIT] = r.mem_err;
    s[ST_SAT_BIT]    = r.sat;
    return s;
  endfunction

  function automatic logic [7:0] result_byte(input result_t r, input logic [1:0] idx);
    logic [7:0] b;
    b = status_byte(r);
    case (idx)
      2'd1: b = r.count[23:16];
      2'd2: b = r.count[15:8];
      2'd3: b = r.count[7:0];
      default: b = status_byte(r);
    endcase
    return b;
  endfunction
endpackage

// *** rtl/psr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // System clock
  input  wire logic         rst_i,   // Async reset
  input  wire logic [W-1:0] d_i,     // Asynchronous input
  output logic      [W-1:0] q_o      // Synchronised level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule
`default_nettype wire

// *** rtl/psr_measure.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_measure
  import psr_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Async reset
  input  wire logic        start_i,   // Accepted measurement command
  input  wire logic [23:0] raw_i,     // Raw bridge sample
  input  wire logic [23:0] offset_i,  // Compensation offset
  output logic             busy_o,    // Measurement in progress
  output logic             done_o,    // One-cycle pulse at completion
  output logic [23:0]      count_o,   // Compensated count
  output logic             sat_o      // Math saturated
);
  typedef enum logic [1:0] {
    M_STANDBY = 2'b01,
    M_OPER    = 2'b10
  } mstate_t;
  mstate_t           st_r;
  logic [CNT_W-1:0]  cyc_r;
  logic [24:0]       sum;
  assign sum = {1'b0, raw_i} + {1'b0, offset_i};
  wire finish = (st_r == M_OPER) && (cyc_r == CNT_W'(MEAS_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r    <= M_STANDBY;
      cyc_r   <= '0;
      done_o  <= 1'b0;
      count_o <= '0;
      sat_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (st_r)
        M_STANDBY: if (start_i) begin
          st_r  <= M_OPER;
          cyc_r <= '0;
        end
        M_OPER: begin
          cyc_r <= cyc_r + 1'b1;
          if (finish) begin
            st_r    <= M_STANDBY;
            done_o  <= 1'b1;
            sat_o   <= sum[24];
            count_o <= sum[24] ? COUNT_MAX : sum[23:0];
          end
        end
      endcase
    end
  end
  assign busy_o = (st_r == M_OPER);
endmodule
`default_nettype wire

// *** rtl/psr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_top
  import psr_pkg::*;
(
  input  wire logic        CLK_SYS_I,   // 100 MHz system clock
  input  wire logic        RST_I,       // Async reset, active high
  input  wire logic        RES_N_I,     // Reset pin, active low
  input  wire logic        SS_N_I,      // SPI select, active low
  input  wire logic        SCLK_I,      // SPI / I2C clock
  input  wire logic        MOSI_I,      // SPI data in
  output logic             MISO_O,      // SPI data out
  output logic             MISO_OE_O,   // MISO drive enable
  input  wire logic        SDA_I,       // I2C data in
  output logic             SDA_O,       // I2C data out (always low)
  output logic             SDA_OE_O,    // I2C pull-down enable
  input  wire logic [23:0] RAW_I,       // Raw bridge sample
  input  wire logic [23:0] OFFSET_I,    // Compensation offset
  input  wire logic [23:0] MEM_SUM_I,   // Power-up checksum residue
  output logic             EOC_O        // End of conversion
);
  logic rst;
  logic [3:0] pin_s;
  psr_sync #(.W(4)) u_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .d_i   ({RES_N_I, SS_N_I, SCLK_I, MOSI_I}),
    .q_o   (pin_s)
  );
  logic sda_s;
  psr_sync #(.W(1)) u_sync_sda (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .d_i   (SDA_I),
    .q_o   (sda_s)
  );
  wire res_n = pin_s[3];
  wire ss_n  = pin_s[2];
  wire sck   = pin_s[1];
  wire mosi  = pin_s[0];

  // Power-up sequence; pin reset restarts it
  logic [CNT_W-1:0] pwr_cnt_r;
  logic             powered_r;
  logic             mem_err_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_cnt_r <= '0;
      powered_r <= 1'b0;
      mem_err_r <= 1'b0;
    end else if (!res_n) begin
      pwr_cnt_r <= '0;
      powered_r <= 1'b0;
    end else if (!powered_r) begin
      pwr_cnt_r <= pwr_cnt_r + 1'b1;
      if (pwr_cnt_r == CNT_W'(POWERUP_CYC - 1)) begin
        powered_r <= 1'b1;
        mem_err_r <= (MEM_SUM_I != MEM_SUM_GOOD);
      end
    end
  end
  assign rst = !powered_r;

  // Clock edges found by sampling
  logic sck_d_r;
  logic sda_d_r;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sck_d_r <= 1'b0;
      sda_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck;
      sda_d_r <= sda_s;
    end
  end
  wire sck_rise = sck && !sck_d_r;
  wire sck_fall = !sck && sck_d_r;
  wire i2c_start = sck && sda_d_r && !sda_s;
  wire i2c_stop  = sck && !sda_d_r && sda_s;

  // Measurement engine
  logic        meas_busy;
  logic        meas_done;
  logic [23:0] meas_count;
  logic        meas_sat;
  logic        cmd_go;
  psr_measure u_meas (
    .clk_i    (CLK_SYS_I),
    .rst_i    (RST_I),
    .start_i  (cmd_go),
    .raw_i    (RAW_I),
    .offset_i (OFFSET_I),
    .busy_o   (meas_busy),
    .done_o   (meas_done),
    .count_o  (meas_count),
    .sat_o    (meas_sat)
  );
  result_t res;
  assign res.powered = powered_r;
  assign res.busy    = meas_busy;
  assign res.mem_err = mem_err_r;
  assign res.sat     = meas_sat;
  assign res.count   = meas_count;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) EOC_O <= 1'b0;
    else if (cmd_go) EOC_O <= 1'b0;
    else if (meas_done) EOC_O <= 1'b1;
  end

  // SPI shifter, mode 0
  logic [7:0] spi_sh_r;
  logic [7:0] spi_rx_r;
  logic [2:0] spi_bit_r;
  logic [1:0] spi_byte_r;
  logic [1:0] spi_cmd_r;
  logic       spi_bad_r;
  wire  [7:0] spi_rx_nxt = {spi_rx_r[6:0], mosi};
  wire        spi_byte_end = sck_rise && (spi_bit_r == 3'd7);
  wire  [1:0] spi_byte_nxt = spi_byte_r + 2'd1;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      spi_sh_r   <= '0;
      spi_rx_r   <= '0;
      spi_bit_r  <= '0;
      spi_byte_r <= '0;
      spi_cmd_r  <= '0;
      spi_bad_r  <= 1'b0;
      MISO_O     <= 1'b0;
      MISO_OE_O  <= 1'b0;
    end else if (ss_n || rst) begin
      spi_sh_r   <= status_byte(res);
      spi_bit_r  <= '0;
      spi_byte_r <= '0;
      spi_cmd_r  <= '0;
      spi_bad_r  <= 1'b0;
      MISO_O     <= 1'b0;
      MISO_OE_O  <= 1'b0;
    end else begin
      MISO_OE_O <= 1'b1;
      if (!MISO_OE_O) MISO_O <= spi_sh_r[7];
      if (sck_rise) begin
        spi_rx_r  <= spi_rx_nxt;
        spi_bit_r <= spi_bit_r + 3'd1;
      end
      if (spi_byte_end) begin
        spi_byte_r <= spi_byte_nxt;
        spi_sh_r   <= result_byte(res, spi_byte_nxt);
        if (spi_cmd_r == 2'd0 && spi_rx_nxt != CMD_MEASURE) spi_bad_r <= 1'b1;
        if (spi_cmd_r != 2'd0 && spi_rx_nxt != CMD_PAD) spi_bad_r <= 1'b1;
        if (spi_cmd_r != 2'd3) spi_cmd_r <= spi_cmd_r + 2'd1;
      end else if (sck_fall && spi_bit_r == 3'd0) begin
        // Fresh byte just loaded: its top bit goes out first
        MISO_O   <= spi_sh_r[7];
      end else if (sck_fall) begin
        spi_sh_r <= {spi_sh_r[6:0], 1'b0};
        MISO_O   <= spi_sh_r[6];
      end
    end
  end
  wire spi_cmd_ok = spi_byte_end && spi_cmd_r == 2'(CMD_BYTES - 1)
                    && !spi_bad_r && spi_rx_nxt == CMD_PAD;

  // I2C target, open drain
  typedef enum logic [5:0] {
    I_IDLE = 6'b000001,
    I_ADDR = 6'b000010,
    I_AACK = 6'b000100,
    I_WR   = 6'b001000,
    I_RD   = 6'b010000,
    I_MACK = 6'b100000
  } istate_t;
  istate_t    ist_r;
  logic [7:0] i_sh_r;
  logic [3:0] i_bit_r;
  logic [1:0] i_byte_r;
  logic [1:0] i_cmd_r;
  logic       i_bad_r;
  logic       i_rw_r;
  wire  [7:0] i_sh_nxt = {i_sh_r[6:0], sda_s};
  wire        addr_hit = i_sh_nxt[7:1] == I2C_ADDR;
  logic       i2c_cmd_ok;
  wire  [7:0] i_first_byte = status_byte(res);
  wire  [7:0] i_next_byte  = result_byte(res, i_byte_r + 2'd1);
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ist_r    <= I_IDLE;
      i_sh_r   <= '0;
      i_bit_r  <= '0;
      i_byte_r <= '0;
      i_cmd_r  <= '0;
      i_bad_r  <= 1'b0;
      i_rw_r   <= 1'b0;
      i2c_cmd_ok <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else begin
      i2c_cmd_ok <= 1'b0;
      if (rst || i2c_stop) begin
        ist_r    <= I_IDLE;
        SDA_OE_O <= 1'b0;
        if (i2c_stop && !rst && ist_r != I_IDLE && !i_rw_r && i_cmd_r == 2'(CMD_BYTES)
            && !i_bad_r)
          i2c_cmd_ok <= 1'b1;
      end else if (i2c_start) begin
        ist_r    <= I_ADDR;
        i_bit_r  <= '0;
        i_cmd_r  <= '0;
        i_bad_r  <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else begin
        unique case (ist_r)
          I_IDLE: ;
          I_ADDR, I_WR: if (sck_rise) begin
            i_sh_r  <= i_sh_nxt;
            i_bit_r <= i_bit_r + 4'd1;
            if (i_bit_r == 4'd7) begin
              if (ist_r == I_ADDR && !addr_hit) ist_r <= I_IDLE;
              else begin
                ist_r <= I_AACK;
                if (ist_r == I_ADDR) i_rw_r <= i_sh_nxt[0];
                else begin
                  if (i_cmd_r == 2'd0 && i_sh_nxt != CMD_MEASURE) i_bad_r <= 1'b1;
                  if (i_cmd_r != 2'd0 && i_sh_nxt != CMD_PAD) i_bad_r <= 1'b1;
                  if (i_cmd_r != 2'd3) i_cmd_r <= i_cmd_r + 2'd1;
                end
              end
            end
          end
          I_AACK: begin
            if (sck_fall && !SDA_OE_O) SDA_OE_O <= 1'b1;
            else if (sck_fall) begin
              i_bit_r <= '0;
              if (i_rw_r) begin
                ist_r    <= I_RD;
                i_byte_r <= '0;
                i_sh_r   <= i_first_byte;
                SDA_OE_O <= !i_first_byte[7];
              end else begin
                ist_r    <= I_WR;
                SDA_OE_O <= 1'b0;
              end
            end
          end
          I_RD: if (sck_fall) begin
            i_bit_r <= i_bit_r + 4'd1;
            if (i_bit_r == 4'd7) begin
              ist_r    <= I_MACK;
              SDA_OE_O <= 1'b0;
            end else begin
              i_sh_r   <= {i_sh_r[6:0], 1'b0};
              SDA_OE_O <= !i_sh_r[6];
            end
          end
          I_MACK: if (sck_rise) begin
            if (sda_s) ist_r <= I_IDLE;
            else begin
              ist_r    <= I_AACK;
              i_byte_r <= i_byte_r + 2'd1;
            end
          end else if (sck_fall) begin
            ist_r    <= I_RD;
            i_bit_r  <= '0;
            i_sh_r   <= i_next_byte;
            SDA_OE_O <= !i_next_byte[7];
          end
          default: ist_r <= I_IDLE;
        endcase
      end
    end
  end
  assign SDA_O = 1'b0;

  // Commands while busy are dropped
  assign cmd_go = (spi_cmd_ok || i2c_cmd_ok) && !meas_busy && powered_r;
  // Status bits 7,4,3,1 tied low by status_byte()
endmodule
`default_nettype wire

// *** bench/spi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input  wire logic miso_i,  // Device data
  output logic      ss_n_o,  // Select, active low
  output logic      sclk_o,  // Clock, idles low
  output logic      mosi_o   // Host data
);
  initial begin
    ss_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Linear count to pressure, scaled by 1000 to stay in integers
  function automatic longint to_milli(input longint cnt, input longint cmin,
                                      input longint cmax, input longint pmin,
                                      input longint pmax);
    return (cnt - cmin) * (pmax - pmin) * 1000 / (cmax - cmin) + pmin * 1000;
  endfunction
  // Mode 0, MSB first, both ways at once
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    ss_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      #62.5 sclk_o = 1'b1;
      rx = {rx[30:0], miso_i};
      #62.5 sclk_o = 1'b0;
    end
    #62.5 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #250;
  endtask
endmodule
`default_nettype wire

// *** bench/psr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module psr_checker
  import psr_pkg::*;
(
  input wire logic CLK_SYS_I,  // System clock
  input wire logic RST_I,      // Async reset
  input wire logic RES_N_I,    // Reset pin
  input wire logic SS_N_I,     // SPI select
  input wire logic SCLK_I,     // Serial clock
  input wire logic SDA_I,      // I2C data in
  input wire logic MISO_O,     // SPI data out
  input wire logic MISO_OE_O,  // MISO enable
  input wire logic SDA_OE_O,   // SDA pull-down
  input wire logic EOC_O       // End of conversion
);
  logic [15:0] pwr_cnt;
  logic [15:0] meas_cnt;
  logic        eoc_q;
  // Saturating, so a long idle never wraps into a false early value
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pwr_cnt  <= 16'h0000;
      meas_cnt <= 16'h0000;
      eoc_q    <= 1'b0;
    end else begin
      eoc_q    <= EOC_O;
      pwr_cnt  <= !RES_N_I ? 16'h0000 : pwr_cnt + {15'h0000, pwr_cnt != 16'hffff};
      meas_cnt <= (eoc_q && !EOC_O) ? 16'h0000 : meas_cnt + {15'h0000, meas_cnt != 16'hffff};
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  a_oe_deselect: assert property (SS_N_I [*6] |-> !MISO_OE_O)
    else $error("MISO driven while deselected");
  a_miso_low_phase: assert property (MISO_OE_O && $past(MISO_OE_O) && $changed(MISO_O) |-> !SCLK_I)
    else $error("MISO changed with clock high");
  a_quiet_powerup: assert property (pwr_cnt < POWERUP_CYC |-> !MISO_OE_O)
    else $error("MISO driven during power-up");
  a_first_bit: assert property ($fell(SS_N_I) && pwr_cnt > POWERUP_CYC + 8 |-> ##[1:5] MISO_OE_O)
    else $error("No data after select");
  a_oe_needs_ss: assert property ($rose(MISO_OE_O) |-> !$past(SS_N_I, 2))
    else $error("MISO enabled without select");
  a_eoc_holds: assert property ((EOC_O && RES_N_I && $stable(SCLK_I) && $stable(SDA_I)) [*8] |=> EOC_O)
    else $error("End flag dropped without command");
  a_eoc_after_meas: assert property ($rose(EOC_O) |-> meas_cnt >= MEAS_CYC - 8)
    else $error("Measurement ended early");
  a_sda_ack_phase: assert property ($rose(SDA_OE_O) |-> !SCLK_I)
    else $error("SDA pulled with clock high");
endmodule
bind psr_top psr_checker chk (.CLK_SYS_I, .RST_I, .RES_N_I, .SS_N_I, .SCLK_I, .SDA_I,
  .MISO_O, .MISO_OE_O, .SDA_OE_O, .EOC_O);
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        res_n = 1'b1;
  logic [23:0] raw = 24'h0;
  logic [23:0] offs = 24'h0;
  logic [23:0] msum = 24'h0;
  logic        ss_n, sclk, mosi, miso, miso_oe, sda_o, sda_oe, eoc;
  logic        miso_w, sda_w;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  // Released MISO reads zero, released SDA is pulled up
  assign miso_w = miso_oe ? miso : 1'b0;
  assign sda_w  = sda_oe ? sda_o : 1'b1;
  psr_top dut (.CLK_SYS_I(clk), .RST_I(rst), .RES_N_I(res_n), .SS_N_I(ss_n),
    .SCLK_I(sclk), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .RAW_I(raw), .OFFSET_I(offs), .MEM_SUM_I(msum),
    .EOC_O(eoc));
  spi_host host (.miso_i(miso_w), .ss_n_o(ss_n), .sclk_o(sclk), .mosi_o(mosi));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic measure(input logic [23:0] a, input logic [23:0] b);
    cyc(1);
    raw = a;
    offs = b;
    host.xfer(32'h00aa0000, 24, r);
  endtask
  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_power();
    host.xfer(32'h0, 4, r);
    chk("status in power-up", 32'h0, {28'h0, r[3:0]});
    cyc(POWERUP_CYC + 20);
    host.xfer(32'h0, 8, r);
    chk("status powered", 32'h40, {24'h0, r[7:0]});
    $display("t_power done");
  endtask
  task automatic t_busy();
    int n;
    measure(24'h123456, 24'h000111);
    host.xfer(32'h0, 8, r);
    chk("busy status", 32'h60, {24'h0, r[7:0]});
    chk("eoc busy", 32'h0, {31'h0, eoc});
    host.xfer(32'h00aa0000, 24, r);
    wait_eoc(n);
    // A restarted run would end a full measurement later
    chk("end window", 32'h1, {31'h0, n > MEAS_CYC / 4 && n < MEAS_CYC * 3 / 4});
    chk("eoc done", 32'h1, {31'h0, eoc});
    host.xfer(32'h0, 32, r);
    chk("result", {8'h40, 24'h123567}, r);
    $display("t_busy done");
  endtask
  task automatic t_sat();
    int n;
    measure(24'hffff00, 24'h000200);
    wait_eoc(n);
    host.xfer(32'h0, 32, r);
    chk("saturated", {8'h41, 24'hffffff}, r);
    $display("t_sat done");
  endtask
  task automatic t_abort();
    host.xfer(32'h0, 12, r);
    chk("cut read", 32'h41f, {20'h0, r[11:0]});
    host.xfer(32'h0, 8, r);
    chk("restart read", 32'h41, {24'h0, r[7:0]});
    chk("pressure", 32'd875, 32'(host.to_milli(14260634, 1677722, 15099494, -1, 1)));
    $display("t_abort done");
  endtask
  task automatic t_memerr();
    cyc(1);
    msum = 24'h000001;
    res_n = 1'b0;
    cyc(3);
    res_n = 1'b1;
    cyc(POWERUP_CYC + 20);
    // Saturation flag of the last measurement survives a pin reset
    host.xfer(32'h0, 8, r);
    chk("mem fail", 32'h45, {24'h0, r[7:0]});
    cyc(1);
    msum = 24'h000000;
    host.xfer(32'h0, 8, r);
    chk("mem held", 32'h45, {24'h0, r[7:0]});
    $display("t_memerr done");
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rst = 1'b0;
    t_power();
    t_busy();
    t_sat();
    t_abort();
    t_memerr();
    final_report();
  end
  // Tests need about 50 us
  initial begin
    #200000;
    n_mismatch++;
    $display("Watchdog expired");
    final_report();
  end
endmodule
`default_nettype wire
